// File: hdl/cisr_pkg.sv
// constants, register map and decode type of the codec input, speaker and
// status register bank.
// assumes a 32-bit axi4-lite slave with 16-bit registers in the low half.
`default_nettype none

package cisr_pkg;

  // ************************************************************
  // register indices and byte addresses
  // ************************************************************
  localparam int unsigned LEFT_AMP_IDX      = 'h25;  // left input amp
  localparam int unsigned RIGHT_AMP_IDX     = 'h26;  // right input amp
  localparam int unsigned LEFT_SPK_IDX      = 'h28;  // left speaker gain
  localparam int unsigned RIGHT_SPK_IDX     = 'h29;  // right speaker gain
  localparam int unsigned THERMAL_IDX       = 'h2F;  // thermal status
  localparam int unsigned DETECT_IDX        = 'h30;  // detect and sensors
  localparam int unsigned BYTES_PER_REG     = 4;     // one word per register
  localparam int unsigned LEFT_AMP_ADDR     = LEFT_AMP_IDX * BYTES_PER_REG;
  localparam int unsigned RIGHT_AMP_ADDR    = RIGHT_AMP_IDX * BYTES_PER_REG;
  localparam int unsigned LEFT_SPK_ADDR     = LEFT_SPK_IDX * BYTES_PER_REG;
  localparam int unsigned RIGHT_SPK_ADDR    = RIGHT_SPK_IDX * BYTES_PER_REG;
  localparam int unsigned THERMAL_ADDR      = THERMAL_IDX * BYTES_PER_REG;
  localparam int unsigned DETECT_ADDR       = DETECT_IDX * BYTES_PER_REG;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int unsigned AMP_ON_BIT        = 4;   // amp power enable
  localparam int unsigned COMMIT_BIT        = 8;   // speaker gain commit
  localparam int unsigned ZC_BIT            = 7;   // zero cross enable
  localparam int unsigned RSV_HI_BIT        = 15;  // reserved, keep 1
  localparam int unsigned CUR_THR_LSB       = 12;  // current threshold 14:12
  localparam int unsigned SHORT_THR_LSB     = 10;  // short threshold 11:10
  localparam int unsigned DET_ON_BIT        = 9;   // bias detect enable
  localparam int unsigned CUR_STS_BIT       = 7;   // current exceeded
  localparam int unsigned SHORT_STS_BIT     = 6;   // short exceeded
  localparam int unsigned RSV_LO_BIT        = 5;   // reserved, keep 1
  localparam int unsigned HP_SENS_BIT       = 2;   // headphone sensor on
  localparam int unsigned SPK_SENS_BIT      = 1;   // speaker sensor on

  // ************************************************************
  // reset values and gain codes
  // ************************************************************
  localparam logic [4:0] AMP_CTRL_RST       = 5'h08;  // pin 1 selected
  localparam logic [6:0] GAIN_RST           = 7'h00;  // muted
  localparam logic [6:0] GAIN_MUTE_TOP      = 7'h2F;  // highest mute code
  localparam logic [6:0] GAIN_FLOOR_TOP     = 7'h35;  // last -68 dB code
  localparam logic [6:0] GAIN_UNITY         = 7'h79;  // 0 dB code
  localparam logic [7:0] GAIN_FLOOR_DB      = 8'hBC;  // -68 dB
  localparam logic [7:0] GAIN_MUTE_DB       = 8'h80;  // mute marker
  localparam logic [2:0] CUR_THR_RST        = 3'h0;
  localparam logic [1:0] SHORT_THR_RST      = 2'h0;

  // ************************************************************
  // bus answers
  // ************************************************************
  localparam logic [1:0] RESP_OKAY          = 2'h0;
  localparam logic [1:0] RESP_SLVERR        = 2'h2;

  // decoded register target
  typedef enum {
    CISR_REG_NONE,
    CISR_REG_LEFT_AMP,
    CISR_REG_RIGHT_AMP,
    CISR_REG_LEFT_SPK,
    CISR_REG_RIGHT_SPK,
    CISR_REG_THERMAL,
    CISR_REG_DETECT
  } cisr_reg_e;

endpackage : cisr_pkg

`default_nettype wire

// File: hdl/cisr_regs.sv
// codec input amp, speaker gain, thermal and bias detect register bank.
// assumes an axi4-lite master on clk_sys and analogue comparator levels
// that arrive asynchronously and are synchronised here.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - left amp powered by bit or path
// - right amp powered by bit or path
// - left pin selects, pin 1 default on
// - right pin selects, pin 1 default on
// - commit bit arms both gains, each applied per its zero cross
// - left zero cross delays left gain change
// - right zero cross delays right gain change
// - gain resets muted, low codes mute
// - floor codes -68 dB, then 1 dB steps
// - headphone error temperature status bit 3
// - headphone warning temperature status bit 2
// - speaker error temperature status bit 1
// - speaker warning temperature status bit 0
// - current threshold select, bits 14:12
// - short threshold select, bits 11:10
// - bit 9 enables both bias detectors
// - bit 7 shows current threshold exceeded
// - bit 6 shows short threshold exceeded
// - headphone sensor enable, reset 1
// - speaker sensor enable, reset 1
module cisr_regs
  import cisr_pkg::*;
#(
  parameter int ADDR_W = 8  // byte address width of the slave
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              left_input_path_on,
  input  wire logic              right_input_path_on,
  input  wire logic              left_zero_cross,
  input  wire logic              right_zero_cross,
  input  wire logic              headphone_hot_error,
  input  wire logic              headphone_hot_warning,
  input  wire logic              speaker_hot_error,
  input  wire logic              speaker_hot_warning,
  input  wire logic              bias_current_cmp,
  input  wire logic              bias_short_cmp,
  output logic                   left_amp_power_on,
  output logic                   right_amp_power_on,
  output logic [3:0]             left_amp_pin_sel,
  output logic [3:0]             right_amp_pin_sel,
  output logic [6:0]             left_speaker_gain_code,
  output logic [6:0]             right_speaker_gain_code,
  output logic                   left_speaker_mute,
  output logic                   right_speaker_mute,
  output logic [7:0]             left_speaker_gain_db,
  output logic [7:0]             right_speaker_gain_db,
  output logic                   left_speaker_zero_cross_on,
  output logic                   right_speaker_zero_cross_on,
  output logic                   headphone_temp_sensor_on,
  output logic                   speaker_temp_sensor_on,
  output logic                   bias_detect_on,
  output logic [2:0]             bias_current_threshold_sel,
  output logic [1:0]             bias_short_threshold_sel
);

  // ************************************************************
  // state
  // ************************************************************
  // sync bit order: 0 left zc, 1 right zc, 2 spk warn, 3 spk err,
  // 4 hp warn, 5 hp err, 6 bias short, 7 bias current
  typedef struct packed {
    logic [7:0]        sync1;       // first synchroniser stage
    logic [7:0]        sync2;       // second synchroniser stage
    logic              awready;     // write address ready
    logic              wready;      // write data ready
    logic              aw_full;     // write address held
    logic [ADDR_W-1:0] aw_addr;     // held write address
    logic              w_full;      // write data held
    logic [15:0]       w_data;      // held write data, low half only
    logic [1:0]        w_strb;      // held strobes of the low half
    logic              bvalid;      // write answer pending
    logic [1:0]        bresp;       // write answer code
    logic              arready;     // read address ready
    logic              rvalid;      // read answer pending
    logic [1:0]        rresp;       // read answer code
    logic [15:0]       rdata;       // read answer data
    logic [4:0]        l_amp;       // left amp enable and pin selects
    logic [4:0]        r_amp;       // right amp enable and pin selects
    logic              l_zc;        // left zero cross enable
    logic              r_zc;        // right zero cross enable
    logic [6:0]        l_shadow;    // left gain waiting for commit
    logic [6:0]        r_shadow;    // right gain waiting for commit
    logic [6:0]        l_gain;      // left gain in force
    logic [6:0]        r_gain;      // right gain in force
    logic              l_wait;      // left commit waits for a crossing
    logic              r_wait;      // right commit waits for a crossing
    logic              rsv_hi;      // reserved bit 15
    logic              rsv_lo;      // reserved bit 5
    logic [2:0]        cur_thr;     // current threshold select
    logic [1:0]        short_thr;   // short threshold select
    logic              det_on;      // bias detect enable
    logic              hp_sens;     // headphone sensor enable
    logic              spk_sens;    // speaker sensor enable
    logic [3:0]        therm;       // thermal status, hp err..spk warn
    logic [1:0]        bias_sts;    // current exceeded, short exceeded
    logic              l_pwr;       // left amp power, registered
    logic              r_pwr;       // right amp power, registered
    logic              l_mute;      // left gain code mutes
    logic              r_mute;      // right gain code mutes
    logic [7:0]        l_db;        // left gain in dB, signed
    logic [7:0]        r_db;        // right gain in dB, signed
  } cisr_state_s;

  cisr_state_s st;       // registered state
  cisr_state_s next_st;  // next state

  // ************************************************************
  // functions
  // ************************************************************
  // word address decode shared by the read and write paths
  function automatic cisr_reg_e decode(input logic [ADDR_W-1:0] addr);
    cisr_reg_e r;
    r = CISR_REG_NONE;
    unique case (32'(addr))
      LEFT_AMP_ADDR:  r = CISR_REG_LEFT_AMP;
      RIGHT_AMP_ADDR: r = CISR_REG_RIGHT_AMP;
      LEFT_SPK_ADDR:  r = CISR_REG_LEFT_SPK;
      RIGHT_SPK_ADDR: r = CISR_REG_RIGHT_SPK;
      THERMAL_ADDR:   r = CISR_REG_THERMAL;
      DETECT_ADDR:    r = CISR_REG_DETECT;
      default:        r = CISR_REG_NONE;  // unmapped or misaligned
    endcase
    return r;
  endfunction : decode

  // software view of a register; the commit bit always reads 0
  function automatic logic [15:0] reg_view(input cisr_reg_e r,
                                           input cisr_state_s s);
    logic [15:0] v;
    v = 16'h0000;
    unique case (r)
      CISR_REG_LEFT_AMP:  v[4:0] = s.l_amp;
      CISR_REG_RIGHT_AMP: v[4:0] = s.r_amp;
      CISR_REG_LEFT_SPK:  v[7:0] = {s.l_zc, s.l_shadow};
      CISR_REG_RIGHT_SPK: v[7:0] = {s.r_zc, s.r_shadow};
      CISR_REG_THERMAL:   v[3:0] = s.therm;
      CISR_REG_DETECT: begin
        v[RSV_HI_BIT]                      = s.rsv_hi;
        v[CUR_THR_LSB+2:CUR_THR_LSB]       = s.cur_thr;
        v[SHORT_THR_LSB+1:SHORT_THR_LSB]   = s.short_thr;
        v[DET_ON_BIT]                      = s.det_on;
        v[CUR_STS_BIT]                     = s.bias_sts[1];
        v[SHORT_STS_BIT]                   = s.bias_sts[0];
        v[RSV_LO_BIT]                      = s.rsv_lo;
        v[HP_SENS_BIT]                     = s.hp_sens;
        v[SPK_SENS_BIT]                    = s.spk_sens;
      end
      CISR_REG_NONE: v = 16'h0000;
    endcase
    return v;
  endfunction : reg_view

  // gain code to signed dB; mute codes give the mute marker
  function automatic logic [7:0] gain_db(input logic [6:0] code);
    logic [7:0] d;
    if (code <= GAIN_MUTE_TOP) begin
      d = GAIN_MUTE_DB;
    end else if (code <= GAIN_FLOOR_TOP) begin
      d = GAIN_FLOOR_DB;
    end else begin
      d = 8'({1'b0, code} - {1'b0, GAIN_UNITY});
    end
    return d;
  endfunction : gain_db

  // ************************************************************
  // next state
  // ************************************************************
  // one pass computes bus handling, register writes, commits and the
  // registered copies of every output
  always_comb begin
    cisr_reg_e   wr_reg;
    cisr_reg_e   rd_reg;
    logic [15:0] old_v;
    logic [15:0] wd;
    logic        commit;
    wr_reg  = CISR_REG_NONE;
    rd_reg  = CISR_REG_NONE;
    old_v   = 16'h0000;
    wd      = 16'h0000;
    commit  = 1'b0;
    next_st = st;

    // synchronisers; only stage two is read by logic
    next_st.sync1 = {bias_current_cmp, bias_short_cmp,
                     headphone_hot_error, headphone_hot_warning,
                     speaker_hot_error, speaker_hot_warning,
                     right_zero_cross, left_zero_cross};
    next_st.sync2 = st.sync1;

    // address and data are taken independently, in either order
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_full = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_full = 1'b1;
      next_st.w_data = s_axi_wdata[15:0];
      next_st.w_strb = s_axi_wstrb[1:0];
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end

    // perform the write once both halves are held
    if (st.aw_full && st.w_full && !st.bvalid) begin
      wr_reg          = decode(st.aw_addr);
      old_v           = reg_view(wr_reg, st);
      wd[7:0]         = st.w_strb[0] ? st.w_data[7:0] : old_v[7:0];
      wd[15:8]        = st.w_strb[1] ? st.w_data[15:8] : old_v[15:8];
      next_st.aw_full = 1'b0;
      next_st.w_full  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = RESP_OKAY;
      unique case (wr_reg)
        CISR_REG_LEFT_AMP:  next_st.l_amp = wd[4:0];
        CISR_REG_RIGHT_AMP: next_st.r_amp = wd[4:0];
        CISR_REG_LEFT_SPK: begin
          next_st.l_zc     = wd[ZC_BIT];
          next_st.l_shadow = wd[6:0];
          commit           = wd[COMMIT_BIT];
        end
        CISR_REG_RIGHT_SPK: begin
          next_st.r_zc     = wd[ZC_BIT];
          next_st.r_shadow = wd[6:0];
          commit           = wd[COMMIT_BIT];
        end
        CISR_REG_THERMAL: begin
          // status only; the write is answered and dropped
          next_st.bresp = RESP_OKAY;
        end
        CISR_REG_DETECT: begin
          next_st.rsv_hi    = wd[RSV_HI_BIT];
          next_st.cur_thr   = wd[CUR_THR_LSB+2:CUR_THR_LSB];
          next_st.short_thr = wd[SHORT_THR_LSB+1:SHORT_THR_LSB];
          next_st.det_on    = wd[DET_ON_BIT];
          next_st.rsv_lo    = wd[RSV_LO_BIT];
          next_st.hp_sens   = wd[HP_SENS_BIT];
          next_st.spk_sens  = wd[SPK_SENS_BIT];
        end
        CISR_REG_NONE: next_st.bresp = RESP_SLVERR;
      endcase
    end

    // a commit arms both channels in the same cycle
    if (commit) begin
      next_st.l_wait = 1'b1;
      next_st.r_wait = 1'b1;
    end
    // an armed channel applies at once without zero cross, else at the
    // next crossing; dropping the enable releases a waiting channel
    if (next_st.l_wait && (!next_st.l_zc || st.sync2[0])) begin
      next_st.l_gain = next_st.l_shadow;
      next_st.l_wait = 1'b0;
    end
    if (next_st.r_wait && (!next_st.r_zc || st.sync2[1])) begin
      next_st.r_gain = next_st.r_shadow;
      next_st.r_wait = 1'b0;
    end

    // read path: one read at a time, answered the cycle after it is taken
    if (s_axi_arvalid && st.arready) begin
      rd_reg         = decode(s_axi_araddr);
      next_st.rvalid = 1'b1;
      next_st.rdata  = reg_view(rd_reg, st);
      next_st.rresp  = (rd_reg == CISR_REG_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end

    // readies are registered, so they lag by one cycle; cheaper than a
    // combinational path from the answer handshakes
    next_st.awready = !next_st.aw_full && !next_st.bvalid;
    next_st.wready  = !next_st.w_full && !next_st.bvalid;
    next_st.arready = !next_st.rvalid;

    // status: a disabled sensor or detector reports nothing
    next_st.therm[3]    = st.sync2[5] & next_st.hp_sens;
    next_st.therm[2]    = st.sync2[4] & next_st.hp_sens;
    next_st.therm[1]    = st.sync2[3] & next_st.spk_sens;
    next_st.therm[0]    = st.sync2[2] & next_st.spk_sens;
    next_st.bias_sts[1] = st.sync2[7] & next_st.det_on;
    next_st.bias_sts[0] = st.sync2[6] & next_st.det_on;

    // registered copies of derived outputs
    next_st.l_pwr  = next_st.l_amp[AMP_ON_BIT] | left_input_path_on;
    next_st.r_pwr  = next_st.r_amp[AMP_ON_BIT] | right_input_path_on;
    next_st.l_mute = (next_st.l_gain <= GAIN_MUTE_TOP);
    next_st.r_mute = (next_st.r_gain <= GAIN_MUTE_TOP);
    next_st.l_db   = gain_db(next_st.l_gain);
    next_st.r_db   = gain_db(next_st.r_gain);
  end

  // ************************************************************
  // state register
  // ************************************************************
  // reset puts every field at its documented default
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st           <= '0;
      st.l_amp     <= AMP_CTRL_RST;
      st.r_amp     <= AMP_CTRL_RST;
      st.l_shadow  <= GAIN_RST;
      st.r_shadow  <= GAIN_RST;
      st.l_gain    <= GAIN_RST;
      st.r_gain    <= GAIN_RST;
      st.l_mute    <= 1'b1;
      st.r_mute    <= 1'b1;
      st.l_db      <= GAIN_MUTE_DB;
      st.r_db      <= GAIN_MUTE_DB;
      st.rsv_hi    <= 1'b1;
      st.rsv_lo    <= 1'b1;
      st.cur_thr   <= CUR_THR_RST;
      st.short_thr <= SHORT_THR_RST;
      st.hp_sens   <= 1'b1;
      st.spk_sens  <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ************************************************************
  // outputs, all straight from state
  // ************************************************************
  assign s_axi_awready               = st.awready;
  assign s_axi_wready                = st.wready;
  assign s_axi_bvalid                = st.bvalid;
  assign s_axi_bresp                 = st.bresp;
  assign s_axi_arready               = st.arready;
  assign s_axi_rvalid                = st.rvalid;
  assign s_axi_rresp                 = st.rresp;
  assign s_axi_rdata                 = {16'h0000, st.rdata};
  assign left_amp_power_on           = st.l_pwr;
  assign right_amp_power_on          = st.r_pwr;
  assign left_amp_pin_sel            = st.l_amp[3:0];
  assign right_amp_pin_sel           = st.r_amp[3:0];
  assign left_speaker_gain_code      = st.l_gain;
  assign right_speaker_gain_code     = st.r_gain;
  assign left_speaker_mute           = st.l_mute;
  assign right_speaker_mute          = st.r_mute;
  assign left_speaker_gain_db        = st.l_db;
  assign right_speaker_gain_db       = st.r_db;
  assign left_speaker_zero_cross_on  = st.l_zc;
  assign right_speaker_zero_cross_on = st.r_zc;
  assign headphone_temp_sensor_on    = st.hp_sens;
  assign speaker_temp_sensor_on      = st.spk_sens;
  assign bias_detect_on              = st.det_on;
  assign bias_current_threshold_sel  = st.cur_thr;
  assign bias_short_threshold_sel    = st.short_thr;

endmodule : cisr_regs

`default_nettype wire

// File: testbench/cisr_regs_chk.sv
// checker for the codec register bank, watching only top-level ports.
// assumes clk_sys with active-low asynchronous rst_n.
`timescale 1ns/10ps
`default_nettype none
module cisr_regs_chk (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        left_input_path_on,
  input wire logic        right_input_path_on,
  input wire logic        left_amp_power_on,
  input wire logic        right_amp_power_on,
  input wire logic [6:0]  left_speaker_gain_code,
  input wire logic        left_speaker_mute,
  input wire logic [7:0]  left_speaker_gain_db,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready
);
  // ************************************************************
  // properties, all on clk_sys
  // ************************************************************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_left_amp_path: assert property (left_input_path_on |=> left_amp_power_on)
    else $error("left amp off while path on");
  a_right_amp_path: assert property (right_input_path_on |=> right_amp_power_on)
    else $error("right amp off while path on");
  a_mute_code: assert property (left_speaker_mute == (left_speaker_gain_code <= 7'h2F))
    else $error("mute flag disagrees with gain code");
  a_floor_db: assert property (left_speaker_gain_code inside {[7'h30:7'h35]}
    |-> left_speaker_gain_db == 8'hBC) else $error("floor codes not -68 dB");
  a_step_db: assert property (left_speaker_gain_code >= 7'h36
    |-> left_speaker_gain_db == 8'(left_speaker_gain_code) - 8'h79)
    else $error("gain step not 1 dB per code");
  a_read_stands: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_read_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
    else $error("upper read half not zero");
  a_write_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
endmodule : cisr_regs_chk
bind cisr_regs cisr_regs_chk u_chk (.*);
`default_nettype wire

// File: testbench/tb.sv
// self-checking bench for the codec register bank over axi4-lite.
// assumes cisr_pkg and cisr_regs are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import cisr_pkg::*;
  logic clk_sys, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, bias_detect_on;
  logic [7:0] s_axi_awaddr, s_axi_araddr, left_speaker_gain_db;
  logic [7:0] right_speaker_gain_db;
  logic [2:0] s_axi_awprot, s_axi_arprot, bias_current_threshold_sel;
  logic [31:0] s_axi_wdata, s_axi_rdata, qr[$], qw[$];
  logic [3:0] s_axi_wstrb, left_amp_pin_sel, right_amp_pin_sel;
  logic [1:0] s_axi_bresp, s_axi_rresp, bias_short_threshold_sel;
  logic left_input_path_on, right_input_path_on, left_zero_cross;
  logic right_zero_cross, headphone_hot_error, headphone_hot_warning;
  logic speaker_hot_error, speaker_hot_warning, bias_current_cmp;
  logic bias_short_cmp, left_amp_power_on, right_amp_power_on;
  logic [6:0] left_speaker_gain_code, right_speaker_gain_code;
  logic left_speaker_mute, right_speaker_mute, left_speaker_zero_cross_on;
  logic right_speaker_zero_cross_on, headphone_temp_sensor_on;
  logic speaker_temp_sensor_on;
  logic [15:0] lf;  // lfsr state
  int failures, compares;
  cisr_regs u_dut (.*);
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task automatic test_done;
    if (failures == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr
  // bounded wait for a handshake signal sampled high at an edge
  task automatic wt(ref logic s);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (s !== 1'b1 && n < 40);
    if (n >= 40) begin
      failures++;
      test_done();
    end
  endtask : wt
  task automatic wr(input int a, input logic [15:0] d, input logic [1:0] r);
    qw.push_back({30'h0, r});
    @(posedge clk_sys);
    s_axi_awaddr <= 8'(a);
    s_axi_wdata <= {16'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin wt(s_axi_awready); s_axi_awvalid <= 1'b0; end
      begin wt(s_axi_wready); s_axi_wvalid <= 1'b0; end
    join
    wt(s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input int a, input logic [1:0] r, input logic [15:0] d);
    qr.push_back({14'h0, r, d});
    @(posedge clk_sys);
    s_axi_araddr <= 8'(a);
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    wt(s_axi_arready);
    s_axi_arvalid <= 1'b0;
    wt(s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd
  // watcher: each bus answer is checked against the oldest note
  always @(posedge clk_sys) begin
    if (s_axi_rvalid && s_axi_rready)
      cmp({14'h0, s_axi_rresp, s_axi_rdata[15:0]}, qr.pop_front());
    if (s_axi_bvalid && s_axi_bready) cmp({30'h0, s_axi_bresp}, qw.pop_front());
  end
  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, left_input_path_on, right_input_path_on} = '0;
    {left_zero_cross, right_zero_cross, headphone_hot_error} = '0;
    {headphone_hot_warning, speaker_hot_error, speaker_hot_warning} = '0;
    {bias_current_cmp, bias_short_cmp, s_axi_awprot, s_axi_arprot} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'h3;
    lf = 16'h002A;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    cmp(32'({left_amp_pin_sel, right_amp_pin_sel, headphone_temp_sensor_on,
      speaker_temp_sensor_on, left_speaker_mute}), 32'h447);
    rd(DETECT_ADDR, RESP_OKAY, 16'h8026);
    rd(LEFT_AMP_ADDR, RESP_OKAY, 16'h0008);
    rd(RIGHT_AMP_ADDR, RESP_OKAY, 16'h0008);
    rd(RIGHT_SPK_ADDR, RESP_OKAY, 16'h0000);
    rd(8'h00, RESP_SLVERR, 16'h0000);
    wr(8'h04, 16'hFFFF, RESP_SLVERR);
    wr(LEFT_SPK_ADDR, 16'h0079, RESP_OKAY);
    repeat (4) @(posedge clk_sys);
    cmp(32'(left_speaker_gain_code), 32'h0);
    wr(RIGHT_SPK_ADDR, 16'h0135, RESP_OKAY);
    repeat (3) @(posedge clk_sys);
    cmp({left_speaker_gain_code, right_speaker_gain_code, left_speaker_gain_db,
      right_speaker_gain_db}, {7'h79, 7'h35, 8'h00, 8'hBC});
    rd(RIGHT_SPK_ADDR, RESP_OKAY, 16'h0035);
    wr(LEFT_SPK_ADDR, 16'h01FF, RESP_OKAY);
    repeat (5) @(posedge clk_sys);
    cmp(32'(left_speaker_gain_code), 32'h79);
    wr(LEFT_SPK_ADDR, 16'h007F, RESP_OKAY);
    repeat (3) @(posedge clk_sys);
    cmp(32'({left_speaker_gain_code, left_speaker_gain_db}), 32'h7F06);
    wr(LEFT_SPK_ADDR, 16'h01F9, RESP_OKAY);
    repeat (3) @(posedge clk_sys);
    cmp(32'(left_speaker_gain_code), 32'h7F);
    left_zero_cross <= 1'b1;
    repeat (4) @(posedge clk_sys);
    cmp(32'({left_speaker_gain_code, left_speaker_zero_cross_on,
      right_speaker_zero_cross_on, right_speaker_mute}), 32'h3CC);
    {headphone_hot_error, headphone_hot_warning, speaker_hot_error} <= 3'h7;
    {speaker_hot_warning, bias_current_cmp, bias_short_cmp} <= 3'h7;
    wr(THERMAL_ADDR, 16'h0000, RESP_OKAY);
    rd(THERMAL_ADDR, RESP_OKAY, 16'h000F);
    wr(DETECT_ADDR, 16'hAE26, RESP_OKAY);
    repeat (4) @(posedge clk_sys);
    rd(DETECT_ADDR, RESP_OKAY, 16'hAEE6);
    cmp(32'({bias_detect_on, bias_current_threshold_sel,
      bias_short_threshold_sel}), 32'h2B);
    wr(DETECT_ADDR, 16'h8020, RESP_OKAY);
    repeat (4) @(posedge clk_sys);
    rd(THERMAL_ADDR, RESP_OKAY, 16'h0000);
    rd(DETECT_ADDR, RESP_OKAY, 16'h8020);
    repeat (8) begin
      lf = lfsr(lf);
      left_input_path_on <= lf[5];
      right_input_path_on <= lf[11];
      wr(LEFT_AMP_ADDR, {11'h0, lf[4:0]}, RESP_OKAY);
      wr(RIGHT_AMP_ADDR, {11'h0, lf[10:6]}, RESP_OKAY);
      rd(LEFT_AMP_ADDR, RESP_OKAY, {11'h0, lf[4:0]});
      cmp(32'({left_amp_pin_sel, left_amp_power_on, right_amp_pin_sel,
        right_amp_power_on}), 32'({lf[3:0], lf[4] | lf[5], lf[9:6],
        lf[10] | lf[11]}));
    end
    test_done();
  end
endmodule : tb
`default_nettype wire
